// ===== shared/i2c_slave_map.vh
// register indices, field positions and reset values of the bus slave block
`ifndef I2C_SLAVE_MAP_VH
`define I2C_SLAVE_MAP_VH

// register indices; the byte address is four times the index
`define IDX_TX_BYTE 16'h4360
`define IDX_RX_BYTE 16'h4362
`define IDX_OWN_ADDR 16'h4364
`define IDX_CONTROL 16'h4366
`define IDX_EVENT_STATUS 16'h4368
`define IDX_ACCESS_STATUS 16'h436A
`define IDX_IRQ_ENABLES 16'h436C
`define IDX_EVENT_MASK 16'h436E

// control register fields
`define CTL_TX_CLEAR 8
`define CTL_ENABLE 7
`define CTL_SOFT_RESET 6
`define CTL_NAK 5
`define CTL_BUS_FREE_REQUEST_ENABLE 4
`define CTL_STRETCH 3
`define CTL_FILTER 2
`define CTL_ASYNC_ADDR_DETECTED_FLAG 1
`define CTL_ACTIVE 0

// event status fields
`define ST_BUS_STATE_TRANSITION_FLAG 7
`define ST_UDF_OVF 5
`define ST_BUS_FREE_REQUEST_FLAG 4
`define ST_DMS 3
`define ST_ASYNC_ADDR_DETECTED_FLAG 2
`define ST_NAK 1
`define ST_STOP 0

// access status fields
`define AS_RX_READY_FLAG 4
`define AS_TX_EMPTY_FLAG 3
`define AS_BUSY 2
`define AS_SEL 1
`define AS_DIR 0

// interrupt enable fields
`define IEN_BUS_STATE_TRANSITION_FLAG 2
`define IEN_RX 1
`define IEN_TX 0

// reset values
`define RST_TX_BYTE 8'h00
`define RST_RX_BYTE 8'h00
`define RST_OWN_ADDR 7'h00
`define RST_CONTROL 9'h000
`define RST_STATUS 8'h00
`define RST_IRQ_EN 3'h0
`define RST_EVENT_MASK 6'h00

// glitch filter: consecutive equal samples before a line level is accepted
`define FILTER_DEPTH 2
`endif

// ===== hw/pin_sync.v
// two flip-flop synchroniser for pin inputs, idle level high
`timescale 1ns/10ps
module pin_sync #(
   parameter W = 2
) (
   input wire hclk,
   input wire hresetn,
   input wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] meta_ff;
   reg [W-1:0] sync_ff;

   // first stage feeds only the second stage
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_ff <= {W{1'b1}};
         sync_ff <= {W{1'b1}};
      end else begin
         meta_ff <= d;
         sync_ff <= meta_ff;
      end
   end

   assign q = sync_ff;
endmodule // pin_sync

// ===== hw/i2c_slave_regs.v
// i2c bus slave with its register set on an ahb-lite slave port
`timescale 1ns/10ps
`include "i2c_slave_map.vh"

module i2c_slave_regs #(
   parameter FILT = `FILTER_DEPTH
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   output wire irq,
   input wire scl_in,
   output wire scl_out,
   output wire scl_oe,
   input wire sda_in,
   output wire sda_out,
   output wire sda_oe
);
   localparam S_IDLE = 7'b0000001;
   localparam S_ADDR = 7'b0000010;
   localparam S_AACK = 7'b0000100;
   localparam S_RX = 7'b0001000;
   localparam S_RACK = 7'b0010000;
   localparam S_TX = 7'b0100000;
   localparam S_TACK = 7'b1000000;

   // register index compare, upper address bits must be zero
   function hit;
      input [31:0] a;
      input [15:0] idx;
      begin
         hit = (a[31:18] == 14'h0000) && (a[17:2] == idx);
      end
   endfunction

   reg [31:0] hrdata_ff;
   reg hreadyout_ff;
   reg hresp_ff;
   reg irq_ff;
   reg low_ff;
   reg scl_oe_ff;
   reg sda_oe_ff;
   reg [31:0] addr_ff;
   reg wr_pend_ff;
   reg rd_pend_ff;
   reg [7:0] tx_byte_ff;
   reg [7:0] rx_byte_ff;
   reg [6:0] own_addr_ff;
   reg [8:0] ctl_ff;
   reg [7:0] stat_ff;
   reg [2:0] ien_ff;
   reg [5:0] emask_ff;
   reg rx_ready_ff;
   reg tx_empty_ff;
   reg busy_ff;
   reg selected_ff;
   reg dir_ff;
   reg [6:0] st_ff;
   reg [3:0] cnt_ff;
   reg [7:0] shift_ff;
   reg ack_ph_ff;
   reg [1:0] line_d_ff;
   wire [1:0] sync_w;
   wire [1:0] filt_w;
   wire scl_w;
   wire sda_w;

   assign hrdata = hrdata_ff;
   assign hreadyout = hreadyout_ff;
   assign hresp = hresp_ff;
   assign irq = irq_ff;
   assign scl_out = low_ff;
   assign sda_out = low_ff;
   assign scl_oe = scl_oe_ff;
   assign sda_oe = sda_oe_ff;

   pin_sync #(
      .W(2)
   ) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .d({scl_in, sda_in}),
      .q(sync_w)
   );

   // optional glitch filter per line: level accepted after FILT equal samples
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_filt
         reg [3:0] run_ff;
         reg line_bit_ff;
         // each line bit has its own flip-flop, so no vector has two drivers
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               run_ff <= 4'h0;
               line_bit_ff <= 1'b1;
            end else if (!ctl_ff[`CTL_FILTER] || sync_w[g] == line_bit_ff) begin
               run_ff <= 4'h0;
               line_bit_ff <= sync_w[g];
            end else if (run_ff >= FILT[3:0] - 4'h1) begin
               run_ff <= 4'h0;
               line_bit_ff <= sync_w[g];
            end else begin
               run_ff <= run_ff + 4'h1;
            end
         end
         assign filt_w[g] = line_bit_ff;
      end
   endgenerate
   assign scl_w = filt_w[1];
   assign sda_w = filt_w[0];

   // previous filtered levels for edge detection
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         line_d_ff <= 2'b11;
      end else begin
         line_d_ff <= filt_w;
      end
   end

   wire scl_rise = scl_w & ~line_d_ff[1];
   wire scl_fall = ~scl_w & line_d_ff[1];
   wire start_det = scl_w & line_d_ff[1] & ~sda_w & line_d_ff[0];
   wire stop_det = scl_w & line_d_ff[1] & sda_w & ~line_d_ff[0];

   wire slave_en = ctl_ff[`CTL_ENABLE];
   wire soft_rst = ctl_ff[`CTL_SOFT_RESET];
   wire active = ctl_ff[`CTL_ACTIVE];
   wire addr_match = (shift_ff[7:1] == own_addr_ff);
   wire stretch_need = ctl_ff[`CTL_STRETCH] & (dir_ff ? tx_empty_ff : rx_ready_ff);
   wire ack_end = (scl_fall & ack_ph_ff & ~scl_oe_ff) | (scl_oe_ff & ~stretch_need);
   wire in_ack = |(st_ff & (S_AACK | S_RACK | S_TACK));

   // engine events, one-cycle pulses
   reg rx_done;
   reg tx_load;
   reg nak_ev;
   reg dms_ev;
   reg async_addr_detected_flag_ev;

   // bit level state machine
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_ff <= S_IDLE;
         cnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         ack_ph_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
         scl_oe_ff <= 1'b0;
         selected_ff <= 1'b0;
         dir_ff <= 1'b0;
         rx_done <= 1'b0;
         tx_load <= 1'b0;
         nak_ev <= 1'b0;
         dms_ev <= 1'b0;
         async_addr_detected_flag_ev <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         tx_load <= 1'b0;
         nak_ev <= 1'b0;
         dms_ev <= 1'b0;
         async_addr_detected_flag_ev <= 1'b0;
         if (soft_rst || !slave_en || start_det || stop_det) begin
            st_ff <= (start_det && slave_en && !soft_rst) ? S_ADDR : S_IDLE;
            cnt_ff <= 4'h0;
            ack_ph_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            scl_oe_ff <= 1'b0;
            selected_ff <= 1'b0;
         end else if (in_ack && ack_ph_ff && (ack_end || (scl_fall && !scl_oe_ff))) begin
            // end of an acknowledge slot: enter the next byte; the stretch branch is never taken
            sda_oe_ff <= 1'b0;
            if (!ack_end) begin
               scl_oe_ff <= 1'b1;
            end else begin
               scl_oe_ff <= 1'b0;
               ack_ph_ff <= 1'b0;
               cnt_ff <= 4'h0;
               if (dir_ff) begin
                  st_ff <= S_TX;
                  shift_ff <= tx_byte_ff;
                  sda_oe_ff <= ~tx_byte_ff[7];
                  tx_load <= 1'b1;
               end else begin
                  st_ff <= S_RX;
               end
            end
         end else begin
            case (st_ff)
               S_ADDR: begin
                  if (scl_rise) begin
                     shift_ff <= {shift_ff[6:0], sda_w};
                     cnt_ff <= cnt_ff + 4'h1;
                     if (cnt_ff == 4'h7) begin
                        st_ff <= S_AACK;
                     end
                  end
               end
               S_AACK: begin
                  if (scl_fall) begin
                     if (addr_match && active && !ctl_ff[`CTL_NAK]) begin
                        sda_oe_ff <= 1'b1;
                        selected_ff <= 1'b1;
                        dir_ff <= shift_ff[0];
                        ack_ph_ff <= 1'b1;
                     end else begin
                        st_ff <= S_IDLE; // not ours, or negative answer
                     end
                     // standby detection reports a match without answering
                     async_addr_detected_flag_ev <= addr_match & ~active & ctl_ff[`CTL_ASYNC_ADDR_DETECTED_FLAG];
                  end
               end
               S_RX: begin
                  if (scl_rise) begin
                     shift_ff <= {shift_ff[6:0], sda_w};
                     cnt_ff <= cnt_ff + 4'h1;
                     if (cnt_ff == 4'h7) begin
                        st_ff <= S_RACK;
                        rx_done <= 1'b1;
                     end
                  end
               end
               S_RACK: begin
                  if (scl_fall) begin
                     sda_oe_ff <= ~ctl_ff[`CTL_NAK];
                     ack_ph_ff <= 1'b1;
                  end
               end
               S_TX: begin
                  if (scl_rise && !sda_oe_ff && !sda_w) begin
                     dms_ev <= 1'b1; // line low while we released it
                     st_ff <= S_IDLE;
                  end else if (scl_fall) begin
                     cnt_ff <= cnt_ff + 4'h1;
                     if (cnt_ff == 4'h7) begin
                        sda_oe_ff <= 1'b0;
                        st_ff <= S_TACK;
                     end else begin
                        shift_ff <= {shift_ff[6:0], 1'b0};
                        sda_oe_ff <= ~shift_ff[6];
                     end
                  end
               end
               S_TACK: begin
                  if (scl_rise) begin
                     if (sda_w) begin
                        nak_ev <= 1'b1;
                        st_ff <= S_IDLE;
                     end else begin
                        ack_ph_ff <= 1'b1;
                     end
                  end
               end
               default: begin
                  st_ff <= S_IDLE;
               end
            endcase
         end
      end
   end

   // ahb-lite decode: writes complete in their data phase, reads take one wait
   wire accept = hsel & htrans[1] & hready;
   wire wr_now = wr_pend_ff;
   wire wr_tx = wr_now & hit(addr_ff, `IDX_TX_BYTE);
   wire wr_stat = wr_now & hit(addr_ff, `IDX_EVENT_STATUS);
   wire rd_rx = rd_pend_ff & hit(addr_ff, `IDX_RX_BYTE);
   wire tx_clear = ctl_ff[`CTL_TX_CLEAR];

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_ff <= 32'h00000000;
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         hreadyout_ff <= 1'b1;
         hresp_ff <= 1'b0;
         low_ff <= 1'b0;
      end else begin
         wr_pend_ff <= accept & hwrite;
         rd_pend_ff <= accept & ~hwrite;
         hreadyout_ff <= ~(accept & ~hwrite);
         if (accept) begin
            addr_ff <= haddr;
         end
      end
   end

   // read data mux, loaded during the wait cycle of a read
   reg [15:0] nxt_rdata;
   always @* begin
      nxt_rdata = 16'h0000;
      if (hit(addr_ff, `IDX_TX_BYTE)) begin
         nxt_rdata = {8'h00, tx_byte_ff};
      end else if (hit(addr_ff, `IDX_RX_BYTE)) begin
         nxt_rdata = {8'h00, rx_byte_ff};
      end else if (hit(addr_ff, `IDX_OWN_ADDR)) begin
         nxt_rdata = {9'h000, own_addr_ff};
      end else if (hit(addr_ff, `IDX_CONTROL)) begin
         nxt_rdata = {7'h00, ctl_ff};
      end else if (hit(addr_ff, `IDX_EVENT_STATUS)) begin
         nxt_rdata = {8'h00, stat_ff};
      end else if (hit(addr_ff, `IDX_ACCESS_STATUS)) begin
         nxt_rdata = {11'h000, rx_ready_ff, tx_empty_ff, busy_ff, selected_ff, dir_ff};
      end else if (hit(addr_ff, `IDX_IRQ_ENABLES)) begin
         nxt_rdata = {13'h0000, ien_ff};
      end else if (hit(addr_ff, `IDX_EVENT_MASK)) begin
         nxt_rdata = {10'h000, emask_ff};
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_ff <= 32'h00000000;
      end else if (rd_pend_ff) begin
         hrdata_ff <= {16'h0000, nxt_rdata};
      end
   end

   // software written registers
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         own_addr_ff <= `RST_OWN_ADDR;
         ctl_ff <= `RST_CONTROL;
         ien_ff <= `RST_IRQ_EN;
         emask_ff <= `RST_EVENT_MASK;
      end else if (wr_now) begin
         if (hit(addr_ff, `IDX_OWN_ADDR)) begin
            own_addr_ff <= hwdata[6:0];
         end
         if (hit(addr_ff, `IDX_CONTROL)) begin
            ctl_ff <= hwdata[8:0];
         end
         if (hit(addr_ff, `IDX_IRQ_ENABLES)) begin
            ien_ff <= hwdata[2:0];
         end
         if (hit(addr_ff, `IDX_EVENT_MASK)) begin
            emask_ff <= hwdata[5:0];
         end
      end
   end

   // transmit byte and its empty flag; clear control holds it empty
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_byte_ff <= `RST_TX_BYTE;
         tx_empty_ff <= 1'b0;
      end else if (tx_clear) begin
         tx_byte_ff <= 8'h00;
         tx_empty_ff <= 1'b1;
      end else if (tx_load) begin
         tx_empty_ff <= 1'b1; // shifter took the byte, set wins over a write
      end else if (wr_tx) begin
         tx_byte_ff <= hwdata[7:0];
         tx_empty_ff <= 1'b0;
      end
   end

   // receive byte and ready flag; a new byte wins over the clearing read
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_byte_ff <= `RST_RX_BYTE;
         rx_ready_ff <= 1'b0;
      end else if (rx_done) begin
         rx_byte_ff <= shift_ff;
         rx_ready_ff <= 1'b1;
      end else if (rd_rx || soft_rst) begin
         rx_ready_ff <= 1'b0;
      end
   end

   // bus busy between start and stop
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_ff <= 1'b0;
      end else if (start_det) begin
         busy_ff <= 1'b1;
      end else if (stop_det) begin
         busy_ff <= 1'b0;
      end
   end

   // sticky event flags: set wins over a write-one clear
   reg [7:0] ev;
   always @* begin
      ev = 8'h00;
      ev[`ST_BUS_STATE_TRANSITION_FLAG] = (start_det & ~busy_ff) | (stop_det & busy_ff);
      ev[`ST_UDF_OVF] = (tx_load & tx_empty_ff) | (rx_done & rx_ready_ff);
      ev[`ST_BUS_FREE_REQUEST_FLAG] = stop_det & busy_ff & ctl_ff[`CTL_BUS_FREE_REQUEST_ENABLE];
      ev[`ST_DMS] = dms_ev;
      ev[`ST_ASYNC_ADDR_DETECTED_FLAG] = async_addr_detected_flag_ev;
      ev[`ST_NAK] = nak_ev;
      ev[`ST_STOP] = stop_det & selected_ff;
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stat_ff <= `RST_STATUS;
      end else if (soft_rst) begin
         stat_ff <= `RST_STATUS;
      end else begin
         stat_ff <= (stat_ff & ~(wr_stat ? hwdata[7:0] : 8'h00)) | ev;
      end
   end

   // interrupt level from enabled flags
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= (stat_ff[`ST_BUS_STATE_TRANSITION_FLAG] & ien_ff[`IEN_BUS_STATE_TRANSITION_FLAG]) |
                   (rx_ready_ff & ien_ff[`IEN_RX]) |
                   (tx_empty_ff & ien_ff[`IEN_TX]) |
                   (|(stat_ff[5:0] & emask_ff));
      end
   end
endmodule // i2c_slave_regs

// ===== verification/i2c_slave_regs_sva.sv
// assertion checker for the register block ports
`timescale 1ns/10ps
`include "i2c_slave_map.vh"
module i2c_slave_regs_sva #(
   parameter FILT = 2
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   input wire irq,
   input wire scl_in,
   input wire scl_out,
   input wire scl_oe,
   input wire sda_in,
   input wire sda_out,
   input wire sda_oe
);
   reg wr_ff, rd_ff, map_ff;
   reg [15:0] idx_ff;
   reg [8:0] ctl_ff;
   reg [6:0] adr_ff;
   reg [5:0] msk_ff;
   reg [2:0] ien_ff;
   wire acc = hsel && htrans[1] && hready;
   wire done = rd_ff && hreadyout;
   // bits that may read as one at the register in its data phase
   wire [15:0] live = !map_ff ? 16'h0000 : (idx_ff == `IDX_TX_BYTE || idx_ff == `IDX_RX_BYTE) ? 16'h00FF :
      idx_ff == `IDX_OWN_ADDR ? 16'h007F : idx_ff == `IDX_CONTROL ? 16'h01FF :
      idx_ff == `IDX_EVENT_STATUS ? 16'h00BF : idx_ff == `IDX_ACCESS_STATUS ? 16'h001F :
      idx_ff == `IDX_IRQ_ENABLES ? 16'h0007 : idx_ff == `IDX_EVENT_MASK ? 16'h003F : 16'h0000;
   // follow bus phases and shadow the written configuration
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ff <= 1'b0;
         rd_ff <= 1'b0;
         map_ff <= 1'b0;
         idx_ff <= 16'h0000;
         ctl_ff <= 9'h000;
         adr_ff <= 7'h00;
         msk_ff <= 6'h00;
         ien_ff <= 3'h0;
      end else if (hready) begin
         if (wr_ff && map_ff && idx_ff == `IDX_CONTROL) ctl_ff <= hwdata[8:0];
         if (wr_ff && map_ff && idx_ff == `IDX_OWN_ADDR) adr_ff <= hwdata[6:0];
         if (wr_ff && map_ff && idx_ff == `IDX_EVENT_MASK) msk_ff <= hwdata[5:0];
         if (wr_ff && map_ff && idx_ff == `IDX_IRQ_ENABLES) ien_ff <= hwdata[2:0];
         wr_ff <= acc && hwrite;
         rd_ff <= acc && !hwrite;
         map_ff <= haddr[31:18] == 14'h0000;
         idx_ff <= haddr[17:2];
      end
   end
   default clocking dc @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   a_okay_resp: assert property (acc |=> hresp == 1'b0 [*2]) else $error("error response given");
   a_read_wait: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
   a_write_nowait: assert property (acc && hwrite |=> hreadyout) else $error("write stalled");
   a_reserved_zero: assert property (done |-> (hrdata & ~{16'h0000, live}) == 32'h0)
      else $error("reserved bits read nonzero");
   a_addr_back: assert property (done && map_ff && idx_ff == `IDX_OWN_ADDR |-> hrdata[6:0] == adr_ff)
      else $error("own address readback wrong");
   a_ctl_back: assert property (done && map_ff && idx_ff == `IDX_CONTROL |-> hrdata[8:0] == ctl_ff)
      else $error("control readback wrong");
   a_disabled_quiet: assert property ((!ctl_ff[`CTL_ENABLE]) [*4] |-> !sda_oe && !scl_oe)
      else $error("disabled slave drives a line");
   a_standby_noack: assert property ((!ctl_ff[`CTL_ACTIVE]) [*4] |-> !sda_oe)
      else $error("standby slave drives data");
   a_irq_quiet: assert property ((ien_ff == 3'h0 && msk_ff == 6'h00) [*2] |-> !irq)
      else $error("irq with all sources off");
   c_read: cover property (done);
   c_ack: cover property ($rose(sda_oe));
   c_irq: cover property ($rose(irq));
endmodule // i2c_slave_regs_sva

bind i2c_slave_regs i2c_slave_regs_sva #(.FILT(FILT)) u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .scl_in(scl_in), .scl_out(scl_out),
   .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));

// ===== verification/link_master_model.sv
// behavioural two-wire bus master that pulls the open-drain lines
`timescale 1ns/10ps
module link_master_model #(
   parameter HALF = 80
) (
   input wire scl_line,
   input wire sda_line,
   input wire slow,
   output reg scl_pull,
   output reg sda_pull
);
   integer w;
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
   end
   // release the clock, waiting bounded while the slave stretches it
   task rise;
      begin
         scl_pull = 1'b0;
         w = 0;
         while (scl_line !== 1'b1 && w < 400) begin
            #10;
            w = w + 1;
         end
      end
   endtask
   task start_c;
      begin
         sda_pull = 1'b1;
         #(HALF);
         scl_pull = 1'b1;
      end
   endtask
   task stop_c;
      begin
         #(HALF / 2);
         sda_pull = 1'b1;
         #(HALF / 2);
         rise;
         #(HALF);
         sda_pull = 1'b0;
         #(HALF);
      end
   endtask
   // nine clocks msb first; data changes mid low, sampled mid high
   task bits9(input [8:0] out, output [8:0] got);
      integer i;
      begin
         for (i = 8; i >= 0; i = i - 1) begin
            #(HALF / 2);
            if (slow) #(HALF);
            sda_pull = ~out[i];
            if (slow) #(HALF);
            #(HALF / 2);
            rise;
            #(HALF / 2);
            got[i] = sda_line;
            #(HALF / 2);
            scl_pull = 1'b1;
         end
      end
   endtask
   task put_byte(input [7:0] b, output ack);
      reg [8:0] g;
      begin
         bits9({b, 1'b1}, g);
         ack = ~g[0];
      end
   endtask
   task get_byte(output [7:0] b, input nak);
      reg [8:0] g;
      begin
         bits9({8'hFF, nak}, g);
         b = g[8:1];
      end
   endtask
endmodule // link_master_model

// ===== verification/i2c_slave_regs_test.sv
// self-checking bench of the register block with a link master model
`timescale 1ns/10ps
`include "i2c_slave_map.vh"
module i2c_slave_regs_test;
   reg hclk, hresetn, hsel, hwrite, slow, ack;
   reg [1:0] htrans;
   reg [31:0] haddr, hwdata, seed, v;
   wire [31:0] hrdata;
   wire hreadyout, hresp, irq, scl_out, scl_oe, sda_out, sda_oe, m_scl, m_sda;
   integer fail_count, cmp_count, i, j, k, wn;
   reg [15:0] r, ix;
   reg [7:0] db, tb, rb;
   reg [6:0] sa;
   // open-drain lines with pull-ups
   wire scl_line = (scl_oe ? scl_out : 1'b1) & !m_scl;
   wire sda_line = (sda_oe ? sda_out : 1'b1) & !m_sda;
   i2c_slave_regs DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .scl_in(scl_line), .scl_out(scl_out),
      .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe));
   link_master_model mst (.scl_line(scl_line), .sda_line(sda_line), .slow(slow), .scl_pull(m_scl),
      .sda_pull(m_sda));
   function [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
   endfunction
   // software-writable bits of the registers the access test writes
   function [15:0] rw_bits(input [15:0] x);
      rw_bits = x == `IDX_TX_BYTE ? 16'h00FF : x == `IDX_OWN_ADDR ? 16'h007F :
         x == `IDX_IRQ_ENABLES ? 16'h0007 : 16'h0000;
   endfunction
   task chk(input [15:0] got, input [15:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wait_rdy;
      begin
         @(negedge hclk);
         while (hreadyout !== 1'b1 && wn < 20) begin
            @(negedge hclk);
            wn = wn + 1;
         end
      end
   endtask
   // one single ahb transfer: address phase, then data phase
   task xfer(input w, input [15:0] a, input [15:0] wd, output [15:0] rd);
      begin
         wn = 0;
         @(posedge hclk);
         hsel <= 1'b1;
         htrans <= 2'b10;
         haddr <= {14'h0000, a, 2'b00};
         hwrite <= w;
         wait_rdy;
         @(posedge hclk);
         hsel <= 1'b0;
         htrans <= 2'b00;
         hwdata <= {16'h0000, wd};
         wait_rdy;
         rd = hrdata[15:0];
         @(posedge hclk);
         if (wn >= 20) fail_count = fail_count + 1;
      end
   endtask
   task wrreg(input [15:0] a, input [15:0] d);
      xfer(1'b1, a, d, r);
   endtask
   task rdchk(input [15:0] a, input [15:0] m, input [15:0] e);
      begin
         xfer(1'b0, a, 16'h0000, r);
         chk(r & m, e);
      end
   endtask
   task pin(input e);
      begin
         repeat (2) @(negedge hclk);
         chk({15'h0000, irq}, {15'h0000, e});
      end
   endtask
   task tally_and_finish;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
         if (fail_count == 0 && cmp_count > 0) $display("verification passed");
         else $display("verification failed");
         $finish;
      end
   endtask
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   initial begin
      #400000;
      fail_count = fail_count + 1;
      tally_and_finish;
   end
   initial begin
      {hresetn, hsel, hwrite, slow, htrans, haddr, hwdata} = 0;
      seed = 32'h1DA9;
      fail_count = 0;
      cmp_count = 0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      // reset values, last index unmapped
      for (i = 0; i < 9; i = i + 1) rdchk(16'h4360 + 2 * i, 16'hFFFF, 16'h0000);
      $display("test reset values done");
      for (i = 0; i < 4; i = i + 1) begin
         ix = i == 0 ? `IDX_TX_BYTE : i == 1 ? `IDX_OWN_ADDR : i == 2 ? `IDX_IRQ_ENABLES : `IDX_RX_BYTE;
         v = rnd();
         wrreg(ix, v[15:0]);
         rdchk(ix, 16'hFFFF, v[15:0] & rw_bits(ix));
      end
      $display("test register access done");
      for (k = 0; k < 2; k = k + 1) begin
         v = rnd();
         sa = v[6:0] | 7'h08;
         db = v[15:8];
         tb = v[23:16];
         slow = k;
         wrreg(`IDX_OWN_ADDR, {9'h000, sa});
         wrreg(`IDX_TX_BYTE, {8'h00, tb});
         wrreg(`IDX_IRQ_ENABLES, 16'h0002);
         // disabled, standby, foreign address: all refused
         for (j = 0; j < 3; j = j + 1) begin
            wrreg(`IDX_CONTROL, j == 0 ? 16'h0001 : j == 1 ? 16'h0080 : 16'h0081);
            mst.start_c;
            mst.put_byte({j == 2 ? sa ^ 7'h01 : sa, 1'b0}, ack);
            mst.stop_c;
            chk({15'h0000, ack}, 16'h0000);
            rdchk(`IDX_EVENT_STATUS, 16'h0004, 16'h0000);
         end
         wrreg(`IDX_CONTROL, k ? 16'h0091 : 16'h0081);
         wrreg(`IDX_EVENT_STATUS, 16'h00FF);
         mst.start_c;
         mst.put_byte({sa, 1'b0}, ack);
         chk({15'h0000, ack}, 16'h0001);
         rdchk(`IDX_ACCESS_STATUS, 16'h0007, 16'h0006);
         mst.put_byte(db, ack);
         mst.stop_c;
         rdchk(`IDX_ACCESS_STATUS, 16'h0016, 16'h0010);
         pin(1'b1);
         rdchk(`IDX_EVENT_STATUS, 16'h00BF, 16'h0081 | (k << 4));
         rdchk(`IDX_RX_BYTE, 16'hFFFF, {8'h00, db});
         pin(1'b0);
         wrreg(`IDX_IRQ_ENABLES, 16'h0004);
         pin(1'b1);
         wrreg(`IDX_EVENT_STATUS, 16'h0001);
         rdchk(`IDX_EVENT_STATUS, 16'h00BF, 16'h0080 | (k << 4));
         wrreg(`IDX_EVENT_STATUS, 16'h0080);
         pin(1'b0);
         wrreg(`IDX_IRQ_ENABLES, 16'h0000);
         mst.start_c;
         mst.put_byte({sa, 1'b1}, ack);
         mst.get_byte(rb, 1'b1);
         mst.stop_c;
         chk({8'h00, rb}, {8'h00, tb});
      end
      $display("test link frames done");
      wrreg(`IDX_CONTROL, 16'h0082);
      wrreg(`IDX_EVENT_STATUS, 16'h00FF);
      mst.start_c;
      mst.put_byte({sa, 1'b0}, ack);
      mst.stop_c;
      chk({15'h0000, ack}, 16'h0000);
      rdchk(`IDX_EVENT_STATUS, 16'h0004, 16'h0004);
      $display("test async detect done");
      tally_and_finish;
   end
endmodule // i2c_slave_regs_test
